/* File: rtl/gtb_chan.sv */
`timescale 1ns/100ps
module gtb_chan #(
	parameter int CW = gtb_pkg::GTB_CNT_W,
	parameter int SW = gtb_pkg::GTB_SHOT_W
) (
	// Clock and reset.
	input  wire logic              clk_sys,
	input  wire logic              rst_n,
	// Configuration and control.
	input  wire gtb_pkg::gtb_mode_t mode,
	input  wire logic [CW-1:0]     reload,
	input  wire logic [SW-1:0]     shots,
	input  wire logic              start,
	input  wire logic              stop,
	// State.
	output logic       [CW-1:0]    count,
	output logic                   running,
	output logic                   expire
);
	import gtb_pkg::*;

	gtb_state_t    state;
	gtb_state_t    next_state;
	logic [SW-1:0] left;
	logic [CW-1:0] next_count;
	logic [SW-1:0] next_left;

	// The expiry pulse comes the cycle after the running cycle in which the count sits at zero, unless stop is set.
	wire at_zero    = (state == GTB_RUN) && (count == '0);
	wire keep_going = (mode == GTB_FREE) || ((mode == GTB_MULTI) && (left > GTB_SHOT_ONE));
	wire next_expire = at_zero && !stop;
	wire [SW-1:0] shots_eff = (shots == '0) ? GTB_SHOT_ONE : shots;

	// State sequencing; stop beats start, start restarts a running timer.
	always_comb begin
		next_state = state;
		next_count = count;
		next_left  = left;
		unique case (state)
			GTB_IDLE: begin
				if (start && !stop) begin
					next_state = GTB_RUN;
					next_count = reload;
					next_left  = shots_eff;
				end
			end
			GTB_RUN: begin
				if (stop) begin
					next_state = GTB_IDLE;
				end else if (start) begin
					next_count = reload;
					next_left  = shots_eff;
				end else if (at_zero) begin
					if (keep_going) begin
						next_count = reload;
						if (mode == GTB_MULTI) begin
							next_left = left - GTB_SHOT_ONE;
						end
					end else begin
						next_state = GTB_IDLE;
					end
				end else begin
					next_count = count - 1'b1;
				end
			end
		endcase
	end

	// Counting registers.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state  <= GTB_IDLE;
			count  <= GTB_CNT_RST;
			left   <= GTB_SHOT_RST;
			expire <= 1'b0;
		end else begin
			state  <= next_state;
			count  <= next_count;
			left   <= next_left;
			expire <= next_expire;
		end
	end

	assign running = (state == GTB_RUN);

	// A plain running cycle takes exactly one off the count.
	count_dec_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		running && count != '0 && !start && !stop |=> count == $past(count) - 1'b1)
		else $error("count did not step down by one");

	// Single-shot stops after its one expiry and flags it.
	single_stop_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		running && count == '0 && mode == GTB_SINGLE && !start && !stop |=> !running && expire)
		else $error("single-shot timer kept running");

	// Free-run reloads and keeps going.
	free_reload_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		running && count == '0 && mode == GTB_FREE && !start && !stop
		|=> running && expire && count == $past(reload))
		else $error("free-run timer did not reload");

	// Multi-shot on its last expiry stops.
	multi_end_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		running && count == '0 && mode == GTB_MULTI && left <= GTB_SHOT_ONE && !start && !stop
		|=> !running)
		else $error("multi-shot timer overran its shots");

	// Expire pulse only follows a zero count while running.
	expire_cause_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		expire |-> $past(running) && $past(count) == '0 && !$past(stop))
		else $error("expiry without cause");

endmodule

/* File: rtl/gtb_pkg.sv */
package gtb_pkg;

	// Bank shape.
	localparam int GTB_NUM_TIMERS = 4;
	localparam int GTB_CNT_W      = 24;
	localparam int GTB_SHOT_W     = 8;

	// Reset values of the counting state, and the shot count of one.
	localparam logic [GTB_CNT_W-1:0]  GTB_CNT_RST   = 24'h000000;
	localparam logic [GTB_SHOT_W-1:0] GTB_SHOT_RST  = 8'h00;
	localparam logic [GTB_SHOT_W-1:0] GTB_SHOT_ONE  = 8'h01;

	// Run modes; the fourth code is unused and behaves as single-shot.
	typedef enum logic [1:0] {
		GTB_SINGLE = 2'b00,
		GTB_MULTI  = 2'b01,
		GTB_FREE   = 2'b10
	} gtb_mode_t;

	// Channel states.
	typedef enum logic {
		GTB_IDLE = 1'b0,
		GTB_RUN  = 1'b1
	} gtb_state_t;

endpackage

/* File: rtl/gtb_top.sv */
`timescale 1ns/100ps
module gtb_top #(
	parameter int NT   = gtb_pkg::GTB_NUM_TIMERS,
	parameter int CW   = gtb_pkg::GTB_CNT_W,
	parameter int SW   = gtb_pkg::GTB_SHOT_W,
	parameter int SELW = $clog2(gtb_pkg::GTB_NUM_TIMERS)
) (
	// Clock and reset.
	input  wire logic              clk_sys,
	input  wire logic              rst_n,
	// Per-timer configuration, timer i in slice i.
	input  wire logic [NT*2-1:0]   mode_sel,
	input  wire logic [NT*CW-1:0]  reload_value,
	input  wire logic [NT*SW-1:0]  shot_count,
	// Per-timer control pulses.
	input  wire logic [NT-1:0]     timer_start,
	input  wire logic [NT-1:0]     timer_stop,
	// Capture control.
	input  wire logic              gpio_evt,
	input  wire logic [SELW-1:0]   cap_sel,
	input  wire logic              cap_clear,
	// Timer state and interrupts.
	output logic      [NT-1:0]     timer_irq,
	output logic      [NT-1:0]     timer_running,
	output logic      [NT*CW-1:0]  timer_count,
	// Capture results.
	output logic      [CW-1:0]     cap_value,
	output logic      [SELW-1:0]   cap_src,
	output logic                   cap_flag
);
	import gtb_pkg::*;

	logic [CW-1:0] chan_count [NT];
	logic          gpio_meta;
	logic          gpio_sync;
	logic          gpio_prev;

	// Field pickers for the packed per-timer configuration.
	function automatic gtb_mode_t mode_of(input logic [NT*2-1:0] v, input int idx);
		return gtb_mode_t'(v[idx*2 +: 2]);
	endfunction

	function automatic logic [CW-1:0] reload_of(input logic [NT*CW-1:0] v, input int idx);
		return v[idx*CW +: CW];
	endfunction

	function automatic logic [SW-1:0] shots_of(input logic [NT*SW-1:0] v, input int idx);
		return v[idx*SW +: SW];
	endfunction

	// One independent channel per timer.
	for (genvar i = 0; i < NT; i++) begin : g_chan
		gtb_chan #(
			.CW (CW),
			.SW (SW)
		) u_chan (
			.clk_sys (clk_sys),
			.rst_n   (rst_n),
			.mode    (mode_of(mode_sel, i)),
			.reload  (reload_of(reload_value, i)),
			.shots   (shots_of(shot_count, i)),
			.start   (timer_start[i]),
			.stop    (timer_stop[i]),
			.count   (chan_count[i]),
			.running (timer_running[i]),
			.expire  (timer_irq[i])
		);
		assign timer_count[i*CW +: CW] = chan_count[i];
	end

	// Event edge and the count it picks.
	wire           evt_rise  = gpio_sync && !gpio_prev;
	wire [CW-1:0]  sel_count = chan_count[cap_sel];

	// The GPIO event is a pin, so it is synchronised before use.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			gpio_meta <= 1'b0;
			gpio_sync <= 1'b0;
			gpio_prev <= 1'b0;
		end else begin
			gpio_meta <= gpio_evt;
			gpio_sync <= gpio_meta;
			gpio_prev <= gpio_sync;
		end
	end

	// Capture store; a new event wins over a clear in the same cycle.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			cap_value <= GTB_CNT_RST;
			cap_src   <= '0;
			cap_flag  <= 1'b0;
		end else if (evt_rise) begin
			cap_value <= sel_count;
			cap_src   <= cap_sel;
			cap_flag  <= 1'b1;
		end else if (cap_clear) begin
			cap_flag  <= 1'b0;
		end
	end

	sequence gpio_edge_s;
		!gpio_sync ##1 gpio_sync;
	endsequence

	// The held value is the selected count on the edge cycle.
	capture_value_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		gpio_edge_s |=> cap_value == $past(sel_count) && cap_flag && cap_src == $past(cap_sel))
		else $error("capture did not latch the selected count");

	// Without an edge the held value stays put.
	capture_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!evt_rise |=> $stable(cap_value))
		else $error("capture value changed without an event");

	// A clear with no event drops the flag one cycle later.
	capture_clear_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		cap_clear && !evt_rise |=> !cap_flag)
		else $error("capture flag not cleared");

	// Reset holds every timer output and the capture flag at its idle value.
	reset_idle_a: assert property (@(posedge clk_sys)
		!rst_n |-> timer_irq == '0 && timer_running == '0 && timer_count == '0 && !cap_flag)
		else $error("outputs not idle in reset");

	// A pin rise passes two sync stages and is stored on the cycle its edge is seen.
	sequence pin_rise_s;
		!gpio_evt ##1 gpio_evt;
	endsequence

	sequence capture_seen_s;
		##3 (cap_flag && cap_src == $past(cap_sel));
	endsequence

	// A pin rise reaches the capture store a fixed three cycles later.
	pin_capture_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		pin_rise_s |-> capture_seen_s)
		else $error("pin rise was not captured in time");

	// The source index only moves with a capture.
	capture_src_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!evt_rise |=> $stable(cap_src))
		else $error("capture source changed without an event");

	// An event and a clear in one cycle leave the flag set.
	flag_wins_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		evt_rise && cap_clear |=> cap_flag)
		else $error("clear beat a capture event");

	// The flag stays up until a clear arrives.
	flag_sticky_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		cap_flag && !cap_clear |=> cap_flag)
		else $error("capture flag dropped without a clear");

	// The flag only rises on a detected edge.
	flag_cause_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		$rose(cap_flag) |-> $past(evt_rise))
		else $error("capture flag rose without an event");

	// Per-timer checks on what each channel shows at the top.
	for (genvar i = 0; i < NT; i++) begin : g_chk
		// The last count step of a single-shot period, with no control pulse in the way.
		sequence last_step_s;
			timer_running[i] && chan_count[i] == CW'(1) && !timer_start[i] && !timer_stop[i]
			##1 !timer_start[i] && !timer_stop[i] && mode_of(mode_sel, i) == GTB_SINGLE;
		endsequence

		// The expiry pulse lasts one cycle with the timer already stopped.
		sequence single_end_s;
			timer_irq[i] && !timer_running[i] ##1 !timer_irq[i];
		endsequence

		single_walk_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
			last_step_s |=> single_end_s)
			else $error("single-shot expiry walk broken");

		// A start loads the reload value and runs.
		start_load_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
			timer_start[i] && !timer_stop[i]
			|=> timer_running[i] && chan_count[i] == $past(reload_of(reload_value, i)))
			else $error("start did not load the reload value");

		// A stop halts the timer, keeps its count and swallows the expiry.
		stop_freeze_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
			timer_stop[i] |=> !timer_running[i] && !timer_irq[i] && $stable(chan_count[i]))
			else $error("stop did not freeze the timer");

		// An idle timer holds its count and stays silent until started.
		idle_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
			!timer_running[i] && !timer_start[i]
			|=> !timer_running[i] && !timer_irq[i] && $stable(chan_count[i]))
			else $error("idle timer moved");

		// A running timer with count left keeps running.
		run_keep_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
			timer_running[i] && chan_count[i] != '0 && !timer_stop[i] |=> timer_running[i])
			else $error("timer stopped before its expiry");

		// Each interrupt follows that timer's own zero count.
		irq_own_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
			timer_irq[i] |-> $past(timer_running[i]) && $past(chan_count[i]) == '0)
			else $error("interrupt without its own expiry");
	end

endmodule

/* File: verif/tb.sv */
`timescale 1ns/100ps
module tb;
	import gtb_pkg::*;
	logic        clk_sys;
	logic        rst_n;
	logic [7:0]  mode_sel;
	logic [95:0] reload_value;
	logic [31:0] shot_count;
	logic [3:0]  timer_start;
	logic [3:0]  timer_stop;
	logic        gpio_evt;
	logic [1:0]  cap_sel;
	logic        cap_clear;
	logic [3:0]  timer_irq;
	logic [3:0]  timer_running;
	logic [95:0] timer_count;
	logic [23:0] cap_value;
	logic [1:0]  cap_src;
	logic        cap_flag;
	int          n_errors;
	int          compares;
	int          nr;
	int          ni;
	int          no;
	gtb_top i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .mode_sel(mode_sel),
		.reload_value(reload_value), .shot_count(shot_count), .timer_start(timer_start),
		.timer_stop(timer_stop), .gpio_evt(gpio_evt), .cap_sel(cap_sel), .cap_clear(cap_clear),
		.timer_irq(timer_irq), .timer_running(timer_running), .timer_count(timer_count),
		.cap_value(cap_value), .cap_src(cap_src), .cap_flag(cap_flag));
	// Free-running system clock at 25 MHz.
	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end
	// Prints the counts and the verdict, then ends the run.
	task automatic stop_test();
		$display("compares %0d n_errors %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	// Compares one observed value with its expectation.
	task automatic cmp(input string what, input logic [23:0] exp, input logic [23:0] got);
		compares++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask
	// Pulses one timer's start, or its stop when halt is set, for one cycle.
	task automatic pulse(input bit halt, input int i);
		@(negedge clk_sys);
		if (halt) timer_stop[i] = 1'b1;
		else timer_start[i] = 1'b1;
		@(negedge clk_sys);
		timer_start = 4'h0;
		timer_stop = 4'h0;
	endtask
	// Configures and starts one timer, then tallies its running and interrupt samples.
	task automatic run(input int i, input logic [1:0] m, input logic [23:0] rl,
		input logic [7:0] sh, input int n);
		mode_sel[2*i+:2] = m;
		reload_value[24*i+:24] = rl;
		shot_count[8*i+:8] = sh;
		nr = 0;
		ni = 0;
		no = 0;
		pulse(1'b0, i);
		repeat (n) begin
			nr += timer_running[i];
			ni += timer_irq[i];
			no += |(timer_irq & ~(4'b0001 << i));
			@(negedge clk_sys);
		end
	endtask
	// Waits a bounded time for the capture flag.
	task automatic wait_flag();
		int k;
		for (k = 0; k < 10 && cap_flag !== 1'b1; k++) @(negedge clk_sys);
		if (cap_flag !== 1'b1) begin
			n_errors++;
			$display("[ERR] cap_flag expected 1 seen %b", cap_flag);
			stop_test();
		end
	endtask
	// Single-shot, with the unused mode code acting the same.
	task automatic test_single();
		logic [1:0] m;
		for (int j = 0; j < 2; j++) begin
			m = j ? 2'b11 : GTB_SINGLE;
			run(0, m, 24'h000002, 8'h00, 12);
			cmp("single running", 24'd3, 24'(nr));
			cmp("single irq", 24'd1, 24'(ni));
			cmp("other irq", 24'd0, 24'(no));
			cmp("single count", 24'h000000, timer_count[23:0]);
		end
		$display("test single done");
	endtask
	// Multi-shot with three shots, and zero shots meaning one.
	task automatic test_multi();
		run(1, GTB_MULTI, 24'h000001, 8'h03, 16);
		cmp("multi running", 24'd6, 24'(nr));
		cmp("multi irq", 24'd3, 24'(ni));
		run(1, GTB_MULTI, 24'h000001, 8'h00, 8);
		cmp("multi zero irq", 24'd1, 24'(ni));
		$display("test multi done");
	endtask
	// Free-run repeats until stopped, then stays silent.
	task automatic test_free();
		run(2, GTB_FREE, 24'h000001, 8'h00, 20);
		cmp("free running", 24'd20, 24'(nr));
		run(2, GTB_FREE, 24'h000001, 8'h00, 0);
		for (int k = 0; k < 10 && timer_irq[2] !== 1'b1; k++) @(negedge clk_sys);
		cmp("free irq seen", 24'd1, {23'd0, timer_irq[2]});
		if (timer_irq[2] !== 1'b1) stop_test();
		ni = 0;
		repeat (20) begin
			@(negedge clk_sys);
			ni += timer_irq[2];
		end
		cmp("free irq", 24'd10, 24'(ni));
		pulse(1'b1, 2);
		repeat (2) @(negedge clk_sys);
		cmp("free stopped", 24'd0, {23'd0, timer_running[2] | timer_irq[2]});
		$display("test free done");
	endtask
	// Captures a frozen count, clears the flag, then captures another timer.
	task automatic test_capture();
		run(3, GTB_FREE, 24'h00abcd, 8'h00, 0);
		pulse(1'b1, 3);
		// One decrement passes between the start edge and the stop edge.
		cmp("frozen count", 24'h00abcc, timer_count[95:72]);
		cap_sel = 2'd3;
		gpio_evt = 1'b1;
		wait_flag();
		cmp("cap value", 24'h00abcc, cap_value);
		cmp("cap src", 24'd3, {22'd0, cap_src});
		gpio_evt = 1'b0;
		cap_clear = 1'b1;
		@(negedge clk_sys);
		cap_clear = 1'b0;
		repeat (2) @(negedge clk_sys);
		cmp("cap clear", 24'd0, {23'd0, cap_flag});
		cap_sel = 2'd0;
		gpio_evt = 1'b1;
		cap_clear = 1'b1;
		repeat (3) @(negedge clk_sys);
		cap_clear = 1'b0;
		cmp("cap set wins", 24'd1, {23'd0, cap_flag});
		cmp("cap value 0", 24'h000000, cap_value);
		cmp("cap src 0", 24'd0, {22'd0, cap_src});
		$display("test capture done");
	endtask
	// Main sequence: reset, then each scenario in turn.
	initial begin
		n_errors = 0;
		compares = 0;
		rst_n = 1'b0;
		mode_sel = 8'h00;
		reload_value = 96'h0;
		shot_count = 32'h0;
		timer_start = 4'h0;
		timer_stop = 4'h0;
		gpio_evt = 1'b0;
		cap_sel = 2'd0;
		cap_clear = 1'b0;
		repeat (8) @(negedge clk_sys);
		rst_n = 1'b1;
		test_single();
		test_multi();
		test_free();
		test_capture();
		stop_test();
	end
endmodule
